// ---- regfield_pkg.sv ----
package regfield_pkg;
  localparam int FIELD_W = 8;
  localparam logic [7:0] RW_RESET = 8'h00;
  localparam logic [7:0] RC_RESET = 8'h00;
  localparam logic [7:0] W1C_RESET = 8'h00;
  localparam logic [7:0] LATCH_LOW_RESET = 8'hFF;
  localparam logic [7:0] LATCH_HIGH_RESET = 8'h00;
  localparam logic [7:0] SELF_CLEARING_RESET = 8'h00;
  localparam logic [7:0] WO_RESET = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'h00;
  localparam logic [7:0] RO_RESET = 8'h00;
  localparam logic [7:0] RD_RESET = 8'h00;
  typedef enum logic [3:0] {
    SEL_RW = 4'h0,
    SEL_RO = 4'h1,
    SEL_RC = 4'h2,
    SEL_WO = 4'h3,
    SEL_W1C = 4'h4,
    SEL_LATCH_LOW = 4'h5,
    SEL_LATCH_HIGH = 4'h6,
    SEL_SELF_CLEARING = 4'h7,
    SEL_RSVD = 4'h8
  } field_sel_e;
endpackage : regfield_pkg

// ---- register_field_access_semantics.sv ----
// Functional notes
// RULE1: readable field returns its contents; writable field takes the written value.
// RULE2: read-only field ignores writes and shows its live source.
// RULE3: clear-on-read field clears after a read; writes do nothing.
// RULE4: write-only field reads back an unspecified value; host must ignore it.
// RULE5: write-one-to-clear: ones written clear bits, zeros leave them.
// RULE6: latch-low bit stays low after a drop until read.
// RULE7: read of latch-low releases it so it follows the live status.
// RULE8: latch-high bit stays high after a rise until read.
// RULE9: read of latch-high releases it so it follows the live status.
// RULE10: self-clearing field clears itself after set; zero writes ignored; readable.
// RULE11: host writes zero to reserved fields and ignores their read value.
// RULE12: clearing reads return old value; same-cycle events are kept.
module register_field_access_semantics
  import regfield_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic reset, // synchronous, active high
  input wire logic rd_en, // host read strobe, one cycle
  input wire logic wr_en, // host write strobe, one cycle
  input wire logic [3:0] sel, // field selected, field_sel_e code
  input wire logic [7:0] wr_data, // host write data
  input wire logic [7:0] ro_src, // live read-only source
  input wire logic [7:0] rc_event, // clear-on-read event pulses
  input wire logic [7:0] w1c_event, // write-one-clear event pulses
  input wire logic [7:0] latch_low_cond, // latch-low live condition
  input wire logic [7:0] latch_high_cond, // latch-high live condition
  output logic [7:0] rd_data, // read data, valid cycle after rd_en
  output logic rd_valid, // read data strobe
  output logic [7:0] rw_ctrl, // read/write control value
  output logic [7:0] wo_ctrl, // write-only control value
  output logic [7:0] self_clearing, // self-clearing command bits
  output logic [7:0] w1c_status, // write-one-clear status
  output logic [7:0] latch_low_status // latch-low status view
);
  // internal state that no port shows directly
  logic [7:0] rc_q;
  logic [7:0] latch_high_q;
  logic [7:0] ro_q;
  logic rd_rc;
  logic rd_latch_low;
  logic rd_latch_high;
  logic wr_rw;
  logic wr_wo;
  logic wr_w1c;
  logic wr_self_clearing;
  logic wr_rsvd;

  // field decode, shared by the clearing reads and the write paths below; rd_data decodes sel itself
  assign rd_rc = rd_en && (sel == SEL_RC);
  assign rd_latch_low = rd_en && (sel == SEL_LATCH_LOW);
  assign rd_latch_high = rd_en && (sel == SEL_LATCH_HIGH);
  assign wr_rw = wr_en && (sel == SEL_RW);
  assign wr_wo = wr_en && (sel == SEL_WO);
  assign wr_w1c = wr_en && (sel == SEL_W1C);
  assign wr_self_clearing = wr_en && (sel == SEL_SELF_CLEARING);
  assign wr_rsvd = wr_en && (sel >= SEL_RSVD);

  always_ff @(posedge clk) begin
    if (reset) begin
      rw_ctrl <= RW_RESET;
    end else if (wr_rw) begin
      rw_ctrl <= wr_data; // [RULE1]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wo_ctrl <= WO_RESET;
    end else if (wr_wo) begin
      wo_ctrl <= wr_data; // [RULE1]
    end
  end

  // registered so the read path is uniform; writes never reach it
  always_ff @(posedge clk) begin
    if (reset) begin
      ro_q <= RO_RESET;
    end else begin
      ro_q <= ro_src; // [RULE2]
    end
  end

  // events win over the read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      rc_q <= RC_RESET;
    end else if (rd_rc) begin
      rc_q <= rc_event; // [RULE3] [RULE12]
    end else begin
      rc_q <= rc_q | rc_event;
    end
  end

  // a same-cycle event beats the host clear, so no event is dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      w1c_status <= W1C_RESET;
    end else if (wr_w1c) begin
      w1c_status <= (w1c_status & ~wr_data) | w1c_event; // [RULE5] [RULE12]
    end else begin
      w1c_status <= w1c_status | w1c_event;
    end
  end

  // a read reloads the live condition, so a change in the read cycle is kept
  genvar i;
  generate
    for (i = 0; i < FIELD_W; i++) begin : g_latch
      always_ff @(posedge clk) begin
        if (reset) begin
          latch_low_status[i] <= LATCH_LOW_RESET[i];
        end else if (rd_latch_low) begin
          latch_low_status[i] <= latch_low_cond[i]; // [RULE7] [RULE12]
        end else begin
          latch_low_status[i] <= latch_low_status[i] & latch_low_cond[i]; // [RULE6]
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          latch_high_q[i] <= LATCH_HIGH_RESET[i];
        end else if (rd_latch_high) begin
          latch_high_q[i] <= latch_high_cond[i]; // [RULE9] [RULE12]
        end else begin
          latch_high_q[i] <= latch_high_q[i] | latch_high_cond[i]; // [RULE8]
        end
      end
    end
  endgenerate

  // one-cycle command pulse; zero bits written are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      self_clearing <= SELF_CLEARING_RESET;
    end else if (wr_self_clearing) begin
      self_clearing <= wr_data; // [RULE10]
    end else begin
      self_clearing <= 8'h00; // [RULE10]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en; // [RULE1]
    end
  end

  // read returns the pre-clear value
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= RD_RESET;
    end else if (rd_en) begin
      if (sel == SEL_RW) begin
        rd_data <= rw_ctrl; // [RULE1]
      end else if (sel == SEL_RO) begin
        rd_data <= ro_q; // [RULE2]
      end else if (sel == SEL_RC) begin
        rd_data <= rc_q; // [RULE3] [RULE12]
      end else if (sel == SEL_W1C) begin
        rd_data <= w1c_status; // [RULE1]
      end else if (sel == SEL_LATCH_LOW) begin
        rd_data <= latch_low_status; // [RULE12]
      end else if (sel == SEL_LATCH_HIGH) begin
        rd_data <= latch_high_q; // [RULE12]
      end else if (sel == SEL_SELF_CLEARING) begin
        rd_data <= self_clearing; // [RULE10]
      end else begin
        rd_data <= RSVD_READ; // [RULE4] [RULE11]
      end
    end
  end

  // clear-on-read field
  property p_rc_read_clears;
    @(posedge clk) disable iff (reset)
      (rd_rc && rc_event == 8'h00) |=> (rc_q == 8'h00);
  endproperty
  a_rc_read_clears: assert property (p_rc_read_clears) else $error("rc not cleared"); // [RULE3]

  property p_rc_keeps_write;
    @(posedge clk) disable iff (reset)
      (wr_en && sel == SEL_RC && !rd_rc && rc_event == 8'h00) |=> (rc_q == $past(rc_q));
  endproperty
  a_rc_keeps_write: assert property (p_rc_keeps_write) // [RULE3]
    else $error("rc changed by write");

  property p_rc_event_kept;
    @(posedge clk) disable iff (reset)
      rd_rc |=> (rd_data == $past(rc_q)) && ((rc_q & $past(rc_event)) == $past(rc_event));
  endproperty
  a_rc_event_kept: assert property (p_rc_event_kept) else $error("rc event lost"); // [RULE12]

  // plain control fields and the read strobe
  property p_rw_write;
    @(posedge clk) disable iff (reset)
      wr_rw |=> (rw_ctrl == $past(wr_data));
  endproperty
  a_rw_write: assert property (p_rw_write) else $error("rw write lost"); // [RULE1]

  sequence s_read_rw;
    rd_en && sel == SEL_RW && !wr_en;
  endsequence
  property p_rw_read;
    @(posedge clk) disable iff (reset)
      s_read_rw |=> (rd_valid && rd_data == $past(rw_ctrl));
  endproperty
  a_rw_read: assert property (p_rw_read) else $error("rw read mismatch"); // [RULE1]

  property p_wo_write;
    @(posedge clk) disable iff (reset)
      wr_wo |=> (wo_ctrl == $past(wr_data));
  endproperty
  a_wo_write: assert property (p_wo_write) else $error("wo write lost"); // [RULE1]

  property p_wo_read_fixed;
    @(posedge clk) disable iff (reset)
      (rd_en && sel == SEL_WO) |=> (rd_valid && rd_data == RSVD_READ);
  endproperty
  a_wo_read_fixed: assert property (p_wo_read_fixed) else $error("wo read leaked"); // [RULE4]

  property p_rd_valid_pulse;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (rd_valid == $past(rd_en));
  endproperty
  a_rd_valid_pulse: assert property (p_rd_valid_pulse) else $error("rd_valid wrong"); // [RULE1]

  property p_rsvd_write_ignored;
    @(posedge clk) disable iff (reset)
      wr_rsvd |=> (rw_ctrl == $past(rw_ctrl)) && (wo_ctrl == $past(wo_ctrl))
        && (self_clearing == 8'h00);
  endproperty
  a_rsvd_write_ignored: assert property (p_rsvd_write_ignored) // [RULE11]
    else $error("reserved write took effect");

  // read-only field
  property p_ro_read;
    @(posedge clk) disable iff (reset)
      (rd_en && sel == SEL_RO) ##1 1'b1 |-> (rd_data == $past(ro_src, 2));
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("ro read mismatch"); // [RULE2]

  property p_ro_write_ignored;
    @(posedge clk) disable iff (reset)
      (wr_en && sel == SEL_RO) |=> (rw_ctrl == $past(rw_ctrl)) && (wo_ctrl == $past(wo_ctrl));
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) // [RULE2]
    else $error("ro write took effect");

  // write-one-clear field
  property p_w1c_clear;
    @(posedge clk) disable iff (reset)
      (wr_w1c && w1c_event == 8'h00) |=> (w1c_status == ($past(w1c_status) & ~$past(wr_data)));
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("w1c wrong"); // [RULE5]

  property p_w1c_event_kept;
    @(posedge clk) disable iff (reset)
      (w1c_event != 8'h00) |=> ((w1c_status & $past(w1c_event)) == $past(w1c_event));
  endproperty
  a_w1c_event_kept: assert property (p_w1c_event_kept) // [RULE12]
    else $error("w1c event lost");

  // latch-low status
  property p_latch_low_hold;
    @(posedge clk) disable iff (reset)
      (!latch_low_status[0] && !rd_latch_low) |=> !latch_low_status[0];
  endproperty
  a_latch_low_hold: assert property (p_latch_low_hold) // [RULE6]
    else $error("latch low released early");

  property p_latch_low_no_rise;
    @(posedge clk) disable iff (reset)
      !rd_latch_low |=> ((latch_low_status & ~$past(latch_low_status)) == 8'h00);
  endproperty
  a_latch_low_no_rise: assert property (p_latch_low_no_rise) // [RULE6]
    else $error("latch low rose without read");

  property p_latch_low_release;
    @(posedge clk) disable iff (reset)
      (rd_latch_low && latch_low_cond[0]) |=> latch_low_status[0];
  endproperty
  a_latch_low_release: assert property (p_latch_low_release) // [RULE7]
    else $error("latch low not released");

  sequence s_latch_low_read;
    rd_latch_low;
  endsequence
  property p_latch_low_read_value;
    @(posedge clk) disable iff (reset)
      s_latch_low_read |=> (rd_data == $past(latch_low_status))
        && (latch_low_status == $past(latch_low_cond));
  endproperty
  a_latch_low_read_value: assert property (p_latch_low_read_value) // [RULE12]
    else $error("latch low read wrong");

  // latch-high status
  property p_latch_high_hold;
    @(posedge clk) disable iff (reset)
      (latch_high_q[0] && !rd_latch_high) |=> latch_high_q[0];
  endproperty
  a_latch_high_hold: assert property (p_latch_high_hold) // [RULE8]
    else $error("latch high released early");

  property p_latch_high_no_fall;
    @(posedge clk) disable iff (reset)
      !rd_latch_high |=> (($past(latch_high_q) & ~latch_high_q) == 8'h00);
  endproperty
  a_latch_high_no_fall: assert property (p_latch_high_no_fall) // [RULE8]
    else $error("latch high fell without read");

  property p_latch_high_release;
    @(posedge clk) disable iff (reset)
      (rd_latch_high && !latch_high_cond[0]) |=> !latch_high_q[0];
  endproperty
  a_latch_high_release: assert property (p_latch_high_release) // [RULE9]
    else $error("latch high not released");

  sequence s_latch_high_read;
    rd_latch_high;
  endsequence
  property p_latch_high_read_value;
    @(posedge clk) disable iff (reset)
      s_latch_high_read |=> (rd_data == $past(latch_high_q))
        && (latch_high_q == $past(latch_high_cond));
  endproperty
  a_latch_high_read_value: assert property (p_latch_high_read_value) // [RULE12]
    else $error("latch high read wrong");

  // self-clearing field
  sequence s_self_clearing_set;
    wr_self_clearing && wr_data != 8'h00;
  endsequence
  property p_self_clearing_clear;
    @(posedge clk) disable iff (reset)
      s_self_clearing_set |=> (self_clearing == $past(wr_data))
        ##1 (self_clearing == 8'h00 || $past(wr_self_clearing));
  endproperty
  a_self_clearing_clear: assert property (p_self_clearing_clear) // [RULE10]
    else $error("self clearing field stuck");

  property p_self_clearing_zero_write;
    @(posedge clk) disable iff (reset)
      (wr_self_clearing && wr_data == 8'h00) |=> (self_clearing == 8'h00);
  endproperty
  a_self_clearing_zero_write: assert property (p_self_clearing_zero_write) // [RULE10]
    else $error("zero write took effect");
endmodule : register_field_access_semantics

// ---- reg_host_model.sv ----
module reg_host_model
  import regfield_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic [7:0] rd_data, // read result from the device
  input wire logic rd_valid, // read result strobe
  output logic rd_en, // read strobe
  output logic wr_en, // write strobe
  output logic [3:0] sel, // field select
  output logic [7:0] wr_data // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    sel = 4'h0;
    wr_data = 8'h00;
  end
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    sel <= s;
    wr_data <= (s >= SEL_RSVD) ? 8'h00 : d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  // strobe is one cycle, result lands at the edge that drops it
  task automatic rd(input logic [3:0] s, output logic [7:0] d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    sel <= s;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask : rd
endmodule : reg_host_model

// ---- register_field_access_semantics_tb.sv ----
module register_field_access_semantics_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import regfield_pkg::*;
  localparam int EV_RC = 0;
  localparam int EV_W1C = 1;
  localparam int EV_LOW = 2;
  localparam int EV_HIGH = 3;
  logic clk = 1'b0, reset = 1'b1, rd_en, wr_en, rd_valid;
  logic [3:0] sel;
  logic [7:0] wr_data, rd_data, rw_ctrl, wo_ctrl, self_clearing;
  logic [7:0] w1c_status, latch_low_status;
  logic [7:0] ro_src = 8'h3C, rc_event = 8'h00, w1c_event = 8'h00;
  logic [7:0] latch_low_cond = 8'hFF, latch_high_cond = 8'h00;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  register_field_access_semantics dut_u (.clk(clk), .reset(reset), .rd_en(rd_en),
    .wr_en(wr_en), .sel(sel), .wr_data(wr_data), .ro_src(ro_src), .rc_event(rc_event),
    .w1c_event(w1c_event), .latch_low_cond(latch_low_cond),
    .latch_high_cond(latch_high_cond), .rd_data(rd_data), .rd_valid(rd_valid),
    .rw_ctrl(rw_ctrl), .wo_ctrl(wo_ctrl), .self_clearing(self_clearing),
    .w1c_status(w1c_status), .latch_low_status(latch_low_status));
  reg_host_model host_u (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_en(rd_en),
    .wr_en(wr_en), .sel(sel), .wr_data(wr_data));
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // sanity ceiling well above the seventy or so cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [3:0] s, input logic [7:0] e, input string n);
    logic [7:0] d;
    logic v;
    host_u.rd(s, d, v);
    chk({n, "_valid"}, 8'h01, {7'h00, v});
    chk(n, e, d);
  endtask : rdchk
  task automatic drive(input int which, input logic [7:0] v);
    if (which == EV_RC) rc_event <= v;
    else if (which == EV_W1C) w1c_event <= v;
    else if (which == EV_LOW) latch_low_cond <= v;
    else latch_high_cond <= v;
  endtask : drive
  // one cycle at a, then b with two settling edges; ends off the edge
  task automatic pulse(input int which, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    drive(which, a);
    @(posedge clk);
    drive(which, b);
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse
  task automatic t_rw_wo;
    logic [7:0] d;
    logic v;
    host_u.wr(SEL_RW, 8'hA5);
    chk("rw_ctrl", 8'hA5, rw_ctrl);
    rdchk(SEL_RW, 8'hA5, "rw_read");
    host_u.wr(SEL_WO, 8'h5A);
    chk("wo_ctrl", 8'h5A, wo_ctrl);
    host_u.rd(SEL_WO, d, v);
    chk("wo_read_valid", 8'h01, {7'h00, v});
    host_u.wr(SEL_RSVD, 8'hFF);
    chk("rw_after_rsvd", 8'hA5, rw_ctrl);
    chk("wo_after_rsvd", 8'h5A, wo_ctrl);
  endtask : t_rw_wo
  task automatic t_ro;
    host_u.wr(SEL_RO, 8'hFF);
    rdchk(SEL_RO, 8'h3C, "ro_read");
  endtask : t_ro
  task automatic t_rc;
    pulse(EV_RC, 8'h0A, 8'h00);
    host_u.wr(SEL_RC, 8'hFF);
    rdchk(SEL_RC, 8'h0A, "rc_first");
    fork
      rdchk(SEL_RC, 8'h00, "rc_cleared");
      pulse(EV_RC, 8'h01, 8'h00);
    join
    rdchk(SEL_RC, 8'h01, "rc_kept");
  endtask : t_rc
  task automatic t_w1c;
    pulse(EV_W1C, 8'h0F, 8'h00);
    chk("w1c_set", 8'h0F, w1c_status);
    host_u.wr(SEL_W1C, 8'h05);
    chk("w1c_clear", 8'h0A, w1c_status);
    rdchk(SEL_W1C, 8'h0A, "w1c_read");
  endtask : t_w1c
  task automatic t_latch;
    pulse(EV_LOW, 8'hFE, 8'hFF);
    chk("low_held", 8'hFE, latch_low_status);
    rdchk(SEL_LATCH_LOW, 8'hFE, "low_read");
    chk("low_released", 8'hFF, latch_low_status);
    fork
      rdchk(SEL_LATCH_LOW, 8'hFF, "low_read_event");
      pulse(EV_LOW, 8'hFD, 8'hFF);
    join
    chk("low_event_kept", 8'hFD, latch_low_status);
    rdchk(SEL_LATCH_LOW, 8'hFD, "low_after_event");
    chk("low_released_again", 8'hFF, latch_low_status);
    pulse(EV_HIGH, 8'h01, 8'h00);
    rdchk(SEL_LATCH_HIGH, 8'h01, "high_read");
    rdchk(SEL_LATCH_HIGH, 8'h00, "high_released");
  endtask : t_latch
  task automatic t_sc;
    host_u.wr(SEL_SELF_CLEARING, 8'h05);
    chk("self_clearing_set", 8'h05, self_clearing);
    @(posedge clk);
    #1 chk("self_clearing_clear", 8'h00, self_clearing);
    host_u.wr(SEL_SELF_CLEARING, 8'h00);
    chk("self_clearing_zero_write", 8'h00, self_clearing);
    rdchk(SEL_SELF_CLEARING, 8'h00, "self_clearing_read");
    @(posedge clk);
    #1 chk("rd_valid_drop", 8'h00, {7'h00, rd_valid});
  endtask : t_sc
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    chk("low_reset", LATCH_LOW_RESET, latch_low_status);
    t_rw_wo();
    t_ro();
    t_rc();
    t_w1c();
    t_latch();
    t_sc();
    end_of_test();
  end
endmodule : register_field_access_semantics_tb
